// ==== umb_baud.sv ====
// 16x baud clock generator from a divisor
`default_nettype none
module umb_baud (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // divisor and 16x clock output
   input wire logic [15:0] divisor,
   output logic baud16_out
);
   logic [15:0] cnt_r;
   logic [15:0] half;

   // high for the upper half of each period
   assign half = divisor >> 1;

   // period counter; divisor below two leaves the clock high
   always_ff @(posedge core_clk)
   begin
      if (reset)
         cnt_r <= 16'h0000;
      else if (cnt_r >= divisor - 16'h0001 || divisor < 16'h0002)
         cnt_r <= 16'h0000;
      else
         cnt_r <= cnt_r + 16'h0001;
   end

   // registered output so the pin never glitches
   always_ff @(posedge core_clk)
   begin
      if (reset)
         baud16_out <= 1'b1;
      else
         baud16_out <= (divisor < 16'h0002) || (cnt_r >= half);
   end

   baud_count_a: assert property (@(posedge core_clk) disable iff (reset)
      divisor >= 16'h0002 && $stable(divisor) |-> cnt_r < divisor)
      else $error("baud counter ran past the divisor");
endmodule : umb_baud
`default_nettype wire

// ==== umb_modem_model.sv ====
// modem-side model driving the active-low status inputs
`default_nettype none
module umb_modem_model #(
   parameter int LAG = 2
) (
   // clock
   input wire logic core_clk,
   // asserted-high requests: cts, dsr, cd, ri
   input wire logic [3:0] want,
   // active-low modem pins
   output logic clear_send_b_n,
   output logic set_ready_b_n,
   output logic carrier_b_n,
   output logic ring_b_n
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] pipe_r[LAG] = '{default: 4'h0};
   // a slow modem: pins follow the request LAG cycles late
   always @(posedge core_clk)
   begin
      pipe_r[0] <= want;
      for (int j = 1; j < LAG; j++)
         pipe_r[j] <= pipe_r[j-1];
   end
   // asserted means driven low, lines always driven
   assign {ring_b_n, carrier_b_n, set_ready_b_n, clear_send_b_n} = ~pipe_r[LAG-1];
endmodule : umb_modem_model
`default_nettype wire

// ==== umb_modem_pins.sv ====
// channel b modem pins, multi-function output and clock pins
// Functional notes
// - rts pin is active low, software driven or auto flow control
// - cts pin active low; gates transmit when auto cts enabled
// - dtr pin is active low, driven from software control bit
// - dsr, carrier, ring are plain inputs, no effect on uart
// - two-bit select routes one of three functions to mf pin
// - general output: mf pin low while control bit 3 set
// - control bit 3 clears on reset
// - baud function: mf pin carries the 16x baud clock
// - receive-ready function: mf pin active-low rx ready
// - clock pin in, buffered copy out on second pin
`default_nettype none
module umb_modem_pins #(
   parameter int LEVEL_W = 7
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // modem pins
   output logic req_send_b_n,
   output logic term_ready_b_n,
   input wire logic clear_send_b_n,
   input wire logic set_ready_b_n,
   input wire logic carrier_b_n,
   input wire logic ring_b_n,
   output logic multi_func_out_b_n,
   // clock pins
   output logic clk_buf_out_pin,
   // receive buffer level and transmit gate
   input wire logic [LEVEL_W-1:0] rx_level,
   output logic tx_allow
);
   logic [7:0] modem_control_reg_r;
   logic [7:0] enhanced_feature_reg_r;
   logic [7:0] interrupt_enable_reg_r;
   logic [7:0] alt_function_reg_r;
   logic [15:0] divisor_r;
   logic [7:0] rx_cfg_r;
   logic [3:0] modem_in;
   logic [3:0] modem_sync;
   logic baud_clk_out_b_n;
   logic rx_ready_b_n;
   logic general_out_b_n;
   logic rx_trig_hit;
   logic [LEVEL_W-1:0] trig_level;
   logic [7:0] status;
   logic cts_asserted;
   logic auto_cts;
   logic auto_rts;
   logic [1:0] mf_sel;

   // write decode shared by all control registers
   function automatic logic wr_hit(input logic [3:0] ofs);
      return reg_wr && (reg_addr == ofs);
   endfunction : wr_hit

   // modem control; bit 3 starts clear
   always_ff @(posedge core_clk)
   begin
      if (reset)
         modem_control_reg_r <= umb_pkg::MODEM_CTRL_RST;
      else if (wr_hit(umb_pkg::MODEM_CTRL_OFS))
         modem_control_reg_r <= reg_wdata;
   end

   // enhanced features hold the auto flow control enables
   always_ff @(posedge core_clk)
   begin
      if (reset)
         enhanced_feature_reg_r <= umb_pkg::ENH_FEAT_RST;
      else if (wr_hit(umb_pkg::ENH_FEAT_OFS))
         enhanced_feature_reg_r <= reg_wdata;
   end

   // interrupt enables are held for software only
   always_ff @(posedge core_clk)
   begin
      if (reset)
         interrupt_enable_reg_r <= umb_pkg::INT_EN_RST;
      else if (wr_hit(umb_pkg::INT_EN_OFS))
         interrupt_enable_reg_r <= reg_wdata;
   end

   // alternate function select
   always_ff @(posedge core_clk)
   begin
      if (reset)
         alt_function_reg_r <= umb_pkg::ALT_FUNC_RST;
      else if (wr_hit(umb_pkg::ALT_FUNC_OFS))
         alt_function_reg_r <= reg_wdata;
   end

   // baud divisor, two byte halves
   always_ff @(posedge core_clk)
   begin
      if (reset)
         divisor_r <= umb_pkg::DIVISOR_RST;
      else if (wr_hit(umb_pkg::DIV_LO_OFS))
         divisor_r[7:0] <= reg_wdata;
      else if (wr_hit(umb_pkg::DIV_HI_OFS))
         divisor_r[15:8] <= reg_wdata;
   end

   // receive buffer mode and trigger level
   always_ff @(posedge core_clk)
   begin
      if (reset)
         rx_cfg_r <= umb_pkg::RX_CFG_RST;
      else if (wr_hit(umb_pkg::RX_CFG_OFS))
         rx_cfg_r <= reg_wdata;
   end

   // modem inputs cross in through three flops
   assign modem_in = {ring_b_n, carrier_b_n, set_ready_b_n, clear_send_b_n};

   umb_sync #(
      .WIDTH(4),
      .RST_VAL(4'hF)
   ) u_sync (
      .core_clk(core_clk),
      .reset(reset),
      .async_in(modem_in),
      .sync_out(modem_sync)
   );

   // 16x baud clock for the mf pin
   umb_baud u_baud (
      .core_clk(core_clk),
      .reset(reset),
      .divisor(divisor_r),
      .baud16_out(baud_clk_out_b_n)
   );

   // decoded fields
   assign cts_asserted = !modem_sync[0];
   assign auto_cts = enhanced_feature_reg_r[umb_pkg::EFR_AUTO_CTS_BIT];
   assign auto_rts = enhanced_feature_reg_r[umb_pkg::EFR_AUTO_RTS_BIT];
   assign mf_sel = alt_function_reg_r[umb_pkg::AFR_SEL_MSB:umb_pkg::AFR_SEL_LSB];
   // zero trigger would never release, so treat it as one
   assign trig_level = (rx_cfg_r[umb_pkg::RXC_TRIG_MSB:0] == 7'h00) ? LEVEL_W'(1) :
      LEVEL_W'(rx_cfg_r[umb_pkg::RXC_TRIG_MSB:0]);
   assign rx_trig_hit = rx_level >= trig_level;

   // transmit may start only while cts is asserted under auto cts
   always_ff @(posedge core_clk)
   begin
      if (reset)
         tx_allow <= 1'b1;
      else
         tx_allow <= !auto_cts || cts_asserted;
   end

   // rts: software level, withdrawn by auto rts at the trigger level;
   // auto rts relies on software having set the rts bit first
   always_ff @(posedge core_clk)
   begin
      if (reset)
         req_send_b_n <= 1'b1;
      else
         req_send_b_n <= !(modem_control_reg_r[umb_pkg::MCR_RTS_BIT] &&
            !(auto_rts && rx_trig_hit));
   end

   // dtr is a plain software output
   always_ff @(posedge core_clk)
   begin
      if (reset)
         term_ready_b_n <= 1'b1;
      else
         term_ready_b_n <= !modem_control_reg_r[umb_pkg::MCR_DTR_BIT];
   end

   // rx ready with hysteresis in buffered mode: set at trigger, clear when empty
   always_ff @(posedge core_clk)
   begin
      if (reset)
         rx_ready_b_n <= 1'b1;
      else if (!rx_cfg_r[umb_pkg::RXC_FIFO_EN_BIT])
         rx_ready_b_n <= rx_level == '0;
      else if (rx_trig_hit)
         rx_ready_b_n <= 1'b0;
      else if (rx_level == '0)
         rx_ready_b_n <= 1'b1;
   end

   // general output is active low from control bit 3
   assign general_out_b_n = !modem_control_reg_r[umb_pkg::MCR_OP2_BIT];

   // mf pin selection; the unused code idles high
   always_ff @(posedge core_clk)
   begin
      if (reset)
         multi_func_out_b_n <= 1'b1;
      else
      begin
         unique case (umb_pkg::umb_mf_sel_t'(mf_sel))
            umb_pkg::UMB_MF_GPO: multi_func_out_b_n <= general_out_b_n;
            umb_pkg::UMB_MF_BAUD: multi_func_out_b_n <= baud_clk_out_b_n;
            umb_pkg::UMB_MF_RXRDY: multi_func_out_b_n <= rx_ready_b_n;
            default: multi_func_out_b_n <= 1'b1;
         endcase
      end
   end

   // status shows pin levels as asserted-high; only cts also steers the transmit gate
   always_comb
   begin
      status = 8'h00;
      status[umb_pkg::ST_CTS_BIT] = cts_asserted;
      status[umb_pkg::ST_DSR_BIT] = !modem_sync[1];
      status[umb_pkg::ST_CD_BIT] = !modem_sync[2];
      status[umb_pkg::ST_RI_BIT] = !modem_sync[3];
      status[umb_pkg::ST_RXRDY_BIT] = !rx_ready_b_n;
      status[umb_pkg::ST_TXOK_BIT] = tx_allow;
   end

   // read data stand one cycle after the strobe, zero otherwise
   always_ff @(posedge core_clk)
   begin
      if (reset || !reg_rd)
         reg_rdata <= 8'h00;
      else
      begin
         unique case (reg_addr)
            umb_pkg::MODEM_CTRL_OFS: reg_rdata <= modem_control_reg_r;
            umb_pkg::ENH_FEAT_OFS: reg_rdata <= enhanced_feature_reg_r;
            umb_pkg::INT_EN_OFS: reg_rdata <= interrupt_enable_reg_r;
            umb_pkg::ALT_FUNC_OFS: reg_rdata <= alt_function_reg_r;
            umb_pkg::DIV_LO_OFS: reg_rdata <= divisor_r[7:0];
            umb_pkg::DIV_HI_OFS: reg_rdata <= divisor_r[15:8];
            umb_pkg::RX_CFG_OFS: reg_rdata <= rx_cfg_r;
            umb_pkg::STATUS_OFS: reg_rdata <= status;
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   // buffered reference clock; a flop would halve it, so it passes straight
   assign clk_buf_out_pin = core_clk;

   mf_gpo_a: assert property (@(posedge core_clk) disable iff (reset)
      mf_sel == 2'h0 && modem_control_reg_r[umb_pkg::MCR_OP2_BIT]
      |=> !multi_func_out_b_n)
      else $error("mf pin not low with general output set");

   mf_baud_a: assert property (@(posedge core_clk) disable iff (reset)
      mf_sel == 2'h1 |=> multi_func_out_b_n == $past(baud_clk_out_b_n))
      else $error("mf pin does not carry baud clock");

   mf_rxrdy_a: assert property (@(posedge core_clk) disable iff (reset)
      mf_sel == 2'h2 |=> multi_func_out_b_n == $past(rx_ready_b_n))
      else $error("mf pin does not carry rx ready");

   op2_reset_a: assert property (@(posedge core_clk)
      reset |=> modem_control_reg_r[umb_pkg::MCR_OP2_BIT] == 1'b0)
      else $error("control bit 3 not cleared by reset");

   rts_pin_a: assert property (@(posedge core_clk) disable iff (reset)
      !auto_rts |=> req_send_b_n == !$past(modem_control_reg_r[umb_pkg::MCR_RTS_BIT]))
      else $error("rts pin does not follow control bit");

   dtr_pin_a: assert property (@(posedge core_clk) disable iff (reset)
      1'b1 |=> term_ready_b_n == !$past(modem_control_reg_r[umb_pkg::MCR_DTR_BIT]))
      else $error("dtr pin does not follow control bit");

   cts_gate_a: assert property (@(posedge core_clk) disable iff (reset)
      auto_cts && modem_sync[0] |=> !tx_allow)
      else $error("transmit not gated by deasserted cts");

   rx_ready_a: assert property (@(posedge core_clk) disable iff (reset)
      !rx_cfg_r[umb_pkg::RXC_FIFO_EN_BIT] && rx_level != '0 ##1 1'b1 |-> !rx_ready_b_n)
      else $error("rx ready not asserted with data held");

   rx_drain_a: assert property (@(posedge core_clk) disable iff (reset)
      rx_level == '0 |=> rx_ready_b_n)
      else $error("rx ready held after buffer drained");

   // auto rts must pull the request back once the trigger is reached
   auto_rts_a: assert property (@(posedge core_clk) disable iff (reset)
      auto_rts && rx_trig_hit |=> req_send_b_n)
      else $error("rts not withdrawn at trigger level");

   rts_back_a: assert property (@(posedge core_clk) disable iff (reset)
      modem_control_reg_r[umb_pkg::MCR_RTS_BIT] && !(auto_rts && rx_trig_hit)
      |=> !req_send_b_n)
      else $error("rts not asserted from control bit");

   cts_pass_a: assert property (@(posedge core_clk) disable iff (reset)
      auto_cts && !modem_sync[0] |=> tx_allow)
      else $error("transmit held with cts asserted");

   // without auto cts no modem input may stop the transmitter
   tx_free_a: assert property (@(posedge core_clk) disable iff (reset)
      !auto_cts |=> tx_allow)
      else $error("transmit gated by a modem input");

   rx_hold_a: assert property (@(posedge core_clk) disable iff (reset)
      rx_cfg_r[umb_pkg::RXC_FIFO_EN_BIT] && rx_trig_hit |=> !rx_ready_b_n)
      else $error("rx ready not asserted at trigger level");

   mf_idle_a: assert property (@(posedge core_clk) disable iff (reset)
      mf_sel == 2'h3 |=> multi_func_out_b_n)
      else $error("mf pin not idle on unused select");
endmodule : umb_modem_pins
`default_nettype wire

// ==== umb_modem_pins_bench.sv ====
// self-checking bench for the channel b modem pin block
`default_nettype none
module umb_modem_pins_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [6:0] rx_level = 7'h00;
   logic [3:0] want = 4'h0;
   logic [7:0] reg_rdata;
   logic req_send_b_n, term_ready_b_n, multi_func_out_b_n, clk_buf_out_pin, tx_allow;
   logic clear_send_b_n, set_ready_b_n, carrier_b_n, ring_b_n;
   logic rd_d = 1'b0, look = 1'b0, win = 1'b0, clr = 1'b0;
   logic [7:0] hi_cnt = 8'h00, buf_bad = 8'h00, obs, e;
   logic [1:0] k;
   logic [1:0] kq[$];
   logic [7:0] eq[$];
   logic [31:0] seed = 32'h0000_0048;
   logic [7:0] dv[4] = '{8'h01, 8'h04, 8'h05, 8'h06};
   logic [7:0] hx[4] = '{8'h78, 8'h3C, 8'h48, 8'h3C};
   string nm[4] = '{"pins", "baud_highs", "clk_buf_errors", "reg_rdata"};
   int n_mismatch = 0;
   int total_checks = 0;

   umb_modem_pins #(.LEVEL_W(7)) i_umb_modem_pins (.core_clk(core_clk), .reset(reset),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .req_send_b_n(req_send_b_n), .term_ready_b_n(term_ready_b_n),
      .clear_send_b_n(clear_send_b_n), .set_ready_b_n(set_ready_b_n),
      .carrier_b_n(carrier_b_n), .ring_b_n(ring_b_n),
      .multi_func_out_b_n(multi_func_out_b_n), .clk_buf_out_pin(clk_buf_out_pin),
      .rx_level(rx_level), .tx_allow(tx_allow));
   umb_modem_model #(.LAG(5)) i_umb_modem_model (.core_clk(core_clk), .want(want),
      .clear_send_b_n(clear_send_b_n), .set_ready_b_n(set_ready_b_n),
      .carrier_b_n(carrier_b_n), .ring_b_n(ring_b_n));

   // 100 ns clock
   initial
      forever #50 core_clk = ~core_clk;

   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs

   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : test_done

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr

   // read data is noted now and compared by the monitor a cycle later
   task automatic rd(input logic [3:0] a, input logic [7:0] x);
      kq.push_back(2'h3);
      eq.push_back(x);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
   endtask : rd

   // two edges let a register change reach the pins first
   task automatic chk(input logic [1:0] kind, input logic [7:0] x);
      kq.push_back(kind);
      eq.push_back(x);
      repeat (2) @(posedge core_clk);
      look <= 1'b1;
      @(posedge core_clk);
      look <= 1'b0;
   endtask : chk

   // order: rts, dtr, mf, tx_allow
   task automatic pins(input logic [3:0] p);
      chk(2'h0, {4'h0, p});
   endtask : pins

   task automatic lvl(input logic [6:0] v);
      @(posedge core_clk);
      rx_level <= v;
   endtask : lvl

   // monitor: pops the oldest note whenever a result is due
   always @(posedge core_clk)
   begin
      rd_d <= reg_rd;
      if (clr)
         hi_cnt <= 8'h00;
      else if (win)
         hi_cnt <= hi_cnt + {7'h00, multi_func_out_b_n};
      if (rd_d || look)
      begin
         k = kq.pop_front();
         e = eq.pop_front();
         case (k)
            2'h0: obs = {4'h0, req_send_b_n, term_ready_b_n, multi_func_out_b_n, tx_allow};
            2'h1: obs = hi_cnt;
            2'h2: obs = buf_bad;
            default: obs = reg_rdata;
         endcase
         total_checks++;
         if (obs !== e)
         begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm[k], e, obs);
         end
      end
   end

   // buffered clock must track the input 5 ns after each edge
   always @(core_clk)
   begin
      #5;
      if (clk_buf_out_pin !== core_clk)
         buf_bad <= buf_bad + 8'h01;
   end

   // watchdog, far beyond the under a thousand cycles the run needs
   initial
   begin
      repeat (20000) @(posedge core_clk);
      n_mismatch++;
      test_done();
   end

   initial
   begin
      repeat (8) @(posedge core_clk);
      reset <= 1'b0;
      pins(4'hF);
      rd(umb_pkg::MODEM_CTRL_OFS, 8'h00);
      rd(umb_pkg::RX_CFG_OFS, 8'h01);
      // interrupt enables are storage only, even bit 7
      wr(umb_pkg::INT_EN_OFS, 8'hA5);
      rd(umb_pkg::INT_EN_OFS, 8'hA5);
      wr(umb_pkg::MODEM_CTRL_OFS, 8'h02);
      pins(4'h7);
      wr(umb_pkg::MODEM_CTRL_OFS, 8'h01);
      pins(4'hB);
      wr(umb_pkg::MODEM_CTRL_OFS, 8'h08);
      pins(4'hD);
      wr(umb_pkg::MODEM_CTRL_OFS, 8'h00);
      pins(4'hF);
      // unmapped and read-only places ignore writes
      wr(4'hC, 8'hFF);
      rd(4'hC, 8'h00);
      wr(umb_pkg::STATUS_OFS, 8'hFF);
      rd(umb_pkg::STATUS_OFS, 8'h20);
      // random modem inputs only show in status
      for (int i = 0; i < 4; i++)
      begin
         seed = xs(seed);
         want <= seed[3:0];
         repeat (16) @(posedge core_clk);
         rd(umb_pkg::STATUS_OFS, {4'h2, seed[3:0]});
         pins(4'hF);
      end
      want <= 4'h0;
      wr(umb_pkg::ENH_FEAT_OFS, 8'h80);
      repeat (16) @(posedge core_clk);
      pins(4'hE);
      want <= 4'h1;
      repeat (16) @(posedge core_clk);
      pins(4'hF);
      want <= 4'h0;
      repeat (16) @(posedge core_clk);
      pins(4'hE);
      wr(umb_pkg::ENH_FEAT_OFS, 8'h00);
      pins(4'hF);
      // software asserts rts before auto rts, trigger 16 buffered
      wr(umb_pkg::MODEM_CTRL_OFS, 8'h02);
      wr(umb_pkg::RX_CFG_OFS, 8'h90);
      wr(umb_pkg::ENH_FEAT_OFS, 8'h40);
      pins(4'h7);
      lvl(7'd20);
      pins(4'hF);
      lvl(7'd5);
      pins(4'h7);
      wr(umb_pkg::ENH_FEAT_OFS, 8'h00);
      wr(umb_pkg::MODEM_CTRL_OFS, 8'h00);
      lvl(7'd0);
      wr(umb_pkg::ALT_FUNC_OFS, 8'h04);
      lvl(7'd5);
      pins(4'hF);
      lvl(7'd20);
      pins(4'hD);
      rd(umb_pkg::STATUS_OFS, 8'h30);
      lvl(7'd5);
      pins(4'hD);
      lvl(7'd0);
      pins(4'hF);
      wr(umb_pkg::RX_CFG_OFS, 8'h00);
      for (int i = 0; i < 4; i++)
      begin
         seed = xs(seed);
         lvl(seed[6:0]);
         pins({2'b11, seed[6:0] == 7'h00, 1'b1});
      end
      lvl(7'd0);
      // select 3 and the general output are exclusive
      wr(umb_pkg::ALT_FUNC_OFS, 8'h06);
      wr(umb_pkg::MODEM_CTRL_OFS, 8'h08);
      pins(4'hF);
      wr(umb_pkg::ALT_FUNC_OFS, 8'h00);
      pins(4'hD);
      wr(umb_pkg::MODEM_CTRL_OFS, 8'h00);
      // baud: count high cycles over a whole number of periods
      wr(umb_pkg::ALT_FUNC_OFS, 8'h02);
      for (int i = 0; i < 4; i++)
      begin
         wr(umb_pkg::DIV_LO_OFS, dv[i]);
         repeat (4) @(posedge core_clk);
         clr <= 1'b1;
         @(posedge core_clk);
         clr <= 1'b0;
         win <= 1'b1;
         repeat (120) @(posedge core_clk);
         win <= 1'b0;
         chk(2'h1, hx[i]);
      end
      rd(umb_pkg::DIV_LO_OFS, 8'h06);
      rd(umb_pkg::DIV_HI_OFS, 8'h00);
      // reset mid-run must clear control bit 3 and return the divisor to one
      wr(umb_pkg::ALT_FUNC_OFS, 8'h00);
      wr(umb_pkg::MODEM_CTRL_OFS, 8'h0B);
      pins(4'h1);
      reset <= 1'b1;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      pins(4'hF);
      rd(umb_pkg::MODEM_CTRL_OFS, 8'h00);
      rd(umb_pkg::DIV_LO_OFS, 8'h01);
      chk(2'h2, 8'h00);
      repeat (4) @(posedge core_clk);
      test_done();
   end
endmodule : umb_modem_pins_bench
`default_nettype wire

// ==== umb_pkg.sv ====
// shared constants for the channel b modem pin block
`default_nettype none
package umb_pkg;
   // register offsets on the plain register port
   localparam logic [3:0] MODEM_CTRL_OFS = 4'h0;
   localparam logic [3:0] ENH_FEAT_OFS = 4'h1;
   localparam logic [3:0] INT_EN_OFS = 4'h2;
   localparam logic [3:0] ALT_FUNC_OFS = 4'h3;
   localparam logic [3:0] DIV_LO_OFS = 4'h4;
   localparam logic [3:0] DIV_HI_OFS = 4'h5;
   localparam logic [3:0] RX_CFG_OFS = 4'h6;
   localparam logic [3:0] STATUS_OFS = 4'h7;
   // modem control fields
   localparam int MCR_DTR_BIT = 0;
   localparam int MCR_RTS_BIT = 1;
   localparam int MCR_OP2_BIT = 3;
   // enhanced feature fields
   localparam int EFR_AUTO_RTS_BIT = 6;
   localparam int EFR_AUTO_CTS_BIT = 7;
   // alternate function select field
   localparam int AFR_SEL_LSB = 1;
   localparam int AFR_SEL_MSB = 2;
   // receive configuration fields
   localparam int RXC_FIFO_EN_BIT = 7;
   localparam int RXC_TRIG_MSB = 6;
   // status fields
   localparam int ST_CTS_BIT = 0;
   localparam int ST_DSR_BIT = 1;
   localparam int ST_CD_BIT = 2;
   localparam int ST_RI_BIT = 3;
   localparam int ST_RXRDY_BIT = 4;
   localparam int ST_TXOK_BIT = 5;
   // reset values
   localparam logic [7:0] MODEM_CTRL_RST = 8'h00;
   localparam logic [7:0] ENH_FEAT_RST = 8'h00;
   localparam logic [7:0] INT_EN_RST = 8'h00;
   localparam logic [7:0] ALT_FUNC_RST = 8'h00;
   localparam logic [15:0] DIVISOR_RST = 16'h0001;
   localparam logic [7:0] RX_CFG_RST = 8'h01;
   // multi-function output selections
   typedef enum logic [1:0]
   {
      UMB_MF_GPO = 2'h0,
      UMB_MF_BAUD = 2'h1,
      UMB_MF_RXRDY = 2'h2
   } umb_mf_sel_t;
   // modem inputs pass three flops
   localparam int SYNC_STAGES = 3;
endpackage : umb_pkg
`default_nettype wire

// ==== umb_sync.sv ====
// three-flop synchroniser with agreement filter
`default_nettype none
module umb_sync #(
   parameter int WIDTH = 4,
   parameter logic [WIDTH-1:0] RST_VAL = '1
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // asynchronous input and filtered result
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;

   // shift chain; first stage feeds only the second
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         s1_r <= RST_VAL;
         s2_r <= RST_VAL;
         s3_r <= RST_VAL;
      end
      else
      begin
         s1_r <= async_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // a bit changes only once two later stages agree
   always_ff @(posedge core_clk)
   begin
      if (reset)
         sync_out <= RST_VAL;
      else
      begin
         for (int i = 0; i < WIDTH; i++)
         begin
            if (s2_r[i] == s3_r[i])
               sync_out[i] <= s3_r[i];
         end
      end
   end

   sync_agree_a: assert property (@(posedge core_clk) disable iff (reset)
      !$stable(sync_out) |-> $past(s2_r) == $past(s3_r))
      else $error("filtered input changed without agreement");
endmodule : umb_sync
`default_nettype wire
